/* File: pkg/adc_flags_consts.vh */
// constants of the converter result and status flag block
// assumes a 32-bit classic wishbone slave with byte addresses on adr_i
`ifndef ADC_FLAGS_CONSTS_VH
`define ADC_FLAGS_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFF_CTRL      8'h00
`define OFF_MODE      8'h04
`define OFF_CH_ENA    8'h10
`define OFF_CH_DIS    8'h14
`define OFF_CH_STAT   8'h18
`define OFF_STATUS    8'h1C
`define OFF_LATEST    8'h20
`define OFF_IRQ_MASK  8'h24
`define OFF_IRQ_STAT  8'h28
`define OFF_CDR0      8'h30

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_START    0
`define MODE_SLEEP    0
`define ST_DONE_LSB   0
`define ST_OVR_LSB    8
`define ST_RDY_BIT    16
`define ST_GOVR_BIT   17
`define ST_WIDTH      18
`define LAT_CHAN_LSB  12

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_WORD      32'h0000_0000
`define RST_STAT      18'h0_0000

`endif

/* File: src/adc_result_status_flags.v */
// result registers and status flags of a converter, classic wishbone slave
// assumes the conversion core runs on clk_i and pulses eoc_i once per result
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`include "adc_flags_consts.vh"
`default_nettype none

module adc_result_status_flags #(
   parameter NCH = 8,
   parameter DW  = 10
) (
   // clock, reset, enable
   input  wire            clk_i,
   input  wire            rst_i,
   input  wire            ce_i,
   // wishbone slave
   input  wire [7:0]      adr_i,
   input  wire [31:0]     dat_i,
   input  wire [3:0]      sel_i,
   input  wire            we_i,
   input  wire            cyc_i,
   input  wire            stb_i,
   output reg  [31:0]     dat_o,
   output reg             ack_o,
   // conversion core
   input  wire            eoc_i,
   input  wire [2:0]      eoc_chan_i,
   input  wire [DW-1:0]   eoc_data_i,
   output reg  [NCH-1:0]  chan_en_o,
   output reg             conv_start_o,
   output reg             sleep_o,
   // interrupt
   output reg             irq_o
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function [NCH-1:0] onehot;
      input [2:0] idx;
      begin
         onehot = {{(NCH-1){1'b0}}, 1'b1} << idx;
      end
   endfunction

   function hit;
      input [7:0] adr;
      input [7:0] off;
      begin
         hit = (adr[7:2] == off[7:2]);
      end
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   reg  [DW-1:0]    cdr_mem [0:NCH-1];
   reg  [DW-1:0]    latest_result_reg;
   reg  [2:0]       latest_chan_reg;
   reg  [NCH-1:0]   done_reg;
   reg  [NCH-1:0]   done_next;
   reg  [NCH-1:0]   channel_overrun_flag_reg;
   reg  [NCH-1:0]   channel_overrun_flag_next;
   reg              result_ready_flag_reg;
   reg              result_ready_flag_next;
   reg              any_overrun_flag_reg;
   reg              any_overrun_flag_next;
   reg              sleep_mode_reg;
   reg  [`ST_WIDTH-1:0] irq_mask_reg;
   reg  [`ST_WIDTH-1:0] irq_stat_reg;
   reg  [`ST_WIDTH-1:0] irq_stat_next;
   reg  [31:0]      rd_mux;

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   wire             req      = cyc_i & stb_i & ~ack_o;
   wire             rd       = req & ~we_i;
   wire             wr       = req & we_i & sel_i[0];
   wire [7:0]       cdr_off  = adr_i - `OFF_CDR0;
   wire [5:0]       cdr_idx  = cdr_off[7:2];
   wire             cdr_hit  = (adr_i >= `OFF_CDR0) && (cdr_idx < NCH);
   wire             rd_stat  = rd & hit(adr_i, `OFF_STATUS);
   wire             rd_lat   = rd & hit(adr_i, `OFF_LATEST);
   wire             rd_cdr   = rd & cdr_hit;
   wire             rd_irq   = rd & hit(adr_i, `OFF_IRQ_STAT);
   wire             wr_ena   = wr & hit(adr_i, `OFF_CH_ENA);
   wire             wr_dis   = wr & hit(adr_i, `OFF_CH_DIS);
   wire [NCH-1:0]   dis_now  = wr_dis ? dat_i[NCH-1:0] : {NCH{1'b0}};
   wire [NCH-1:0]   ena_now  = wr_ena ? dat_i[NCH-1:0] : {NCH{1'b0}};

   // ----------------------------------------------------------------------
   // control register writes
   // ----------------------------------------------------------------------
   wire             wr_ctrl  = wr & hit(adr_i, `OFF_CTRL);
   wire             wr_mode  = wr & hit(adr_i, `OFF_MODE);
   wire             wr_mask  = wr & hit(adr_i, `OFF_IRQ_MASK);

   // ----------------------------------------------------------------------
   // end of conversion qualification
   // ----------------------------------------------------------------------
   wire [NCH-1:0]   eoc_oh   = onehot(eoc_chan_i);
   wire             eoc_ok   = eoc_i & |(eoc_oh & chan_en_o & ~dis_now);
   wire             ovr_new  = eoc_ok & |(eoc_oh & done_reg);
   wire             govr_new = eoc_ok & result_ready_flag_reg;

   // ----------------------------------------------------------------------
   // flag next state
   // ----------------------------------------------------------------------
   always @* begin
      done_next                 = done_reg;
      channel_overrun_flag_next = channel_overrun_flag_reg;
      result_ready_flag_next    = result_ready_flag_reg;
      any_overrun_flag_next     = any_overrun_flag_reg;
      if (rd_cdr) begin
         done_next = done_next & ~onehot(cdr_idx[2:0]);
      end
      if (rd_lat) begin
         done_next = done_next & ~onehot(latest_chan_reg);
         result_ready_flag_next = 1'b0;
      end
      if (rd_stat) begin
         channel_overrun_flag_next = {NCH{1'b0}};
         any_overrun_flag_next = 1'b0;
      end
      if (eoc_ok) begin
         done_next = done_next | eoc_oh;
         result_ready_flag_next = 1'b1;
      end
      if (ovr_new) begin
         channel_overrun_flag_next = channel_overrun_flag_next | eoc_oh;
      end
      if (govr_new) begin
         any_overrun_flag_next = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // interrupt status next state
   // ----------------------------------------------------------------------
   wire [`ST_WIDTH-1:0] ev_vec;
   assign ev_vec[`ST_OVR_LSB-1:`ST_DONE_LSB] = eoc_ok ? eoc_oh : {NCH{1'b0}};
   assign ev_vec[`ST_RDY_BIT-1:`ST_OVR_LSB]  = ovr_new ? eoc_oh : {NCH{1'b0}};
   assign ev_vec[`ST_RDY_BIT]                = eoc_ok;
   assign ev_vec[`ST_GOVR_BIT]               = govr_new;

   always @* begin
      irq_stat_next = irq_stat_reg;
      if (rd_irq) begin
         irq_stat_next = `RST_STAT;
      end
      irq_stat_next = irq_stat_next | ev_vec;
   end

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   always @* begin
      rd_mux = `RST_WORD;
      if (cdr_hit) begin
         rd_mux[DW-1:0] = cdr_mem[cdr_idx[2:0]];
      end else if (hit(adr_i, `OFF_MODE)) begin
         rd_mux[`MODE_SLEEP] = sleep_mode_reg;
      end else if (hit(adr_i, `OFF_CH_STAT)) begin
         rd_mux[NCH-1:0] = chan_en_o;
      end else if (hit(adr_i, `OFF_STATUS)) begin
         rd_mux[`ST_OVR_LSB-1:`ST_DONE_LSB] = done_reg;
         rd_mux[`ST_RDY_BIT-1:`ST_OVR_LSB]  = channel_overrun_flag_reg;
         rd_mux[`ST_RDY_BIT]                = result_ready_flag_reg;
         rd_mux[`ST_GOVR_BIT]               = any_overrun_flag_reg;
      end else if (hit(adr_i, `OFF_LATEST)) begin
         rd_mux[DW-1:0] = latest_result_reg;
         rd_mux[`LAT_CHAN_LSB+2:`LAT_CHAN_LSB] = latest_chan_reg;
      end else if (hit(adr_i, `OFF_IRQ_MASK)) begin
         rd_mux[`ST_WIDTH-1:0] = irq_mask_reg;
      end else if (hit(adr_i, `OFF_IRQ_STAT)) begin
         rd_mux[`ST_WIDTH-1:0] = irq_stat_reg;
      end
   end

   // ----------------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= `RST_WORD;
      end else if (ce_i) begin
         ack_o <= req;
         if (rd) begin
            dat_o <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------------
   // conversion-done flags
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         done_reg <= {NCH{1'b0}};
      end else if (ce_i) begin
         done_reg <= done_next;
      end
   end

   // ----------------------------------------------------------------------
   // channel overrun flags
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         channel_overrun_flag_reg <= {NCH{1'b0}};
      end else if (ce_i) begin
         channel_overrun_flag_reg <= channel_overrun_flag_next;
      end
   end

   // ----------------------------------------------------------------------
   // result-ready flag
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         result_ready_flag_reg <= 1'b0;
      end else if (ce_i) begin
         result_ready_flag_reg <= result_ready_flag_next;
      end
   end

   // ----------------------------------------------------------------------
   // general overrun flag
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         any_overrun_flag_reg <= 1'b0;
      end else if (ce_i) begin
         any_overrun_flag_reg <= any_overrun_flag_next;
      end
   end

   // ----------------------------------------------------------------------
   // latest result
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         latest_result_reg <= {DW{1'b0}};
         latest_chan_reg   <= 3'h0;
      end else if (ce_i) begin
         if (eoc_ok) begin
            latest_result_reg <= eoc_data_i;
            latest_chan_reg   <= eoc_chan_i;
         end
      end
   end

   // ----------------------------------------------------------------------
   // channel enables and conversion start
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         chan_en_o    <= {NCH{1'b0}};
         conv_start_o <= 1'b0;
      end else if (ce_i) begin
         chan_en_o    <= (chan_en_o | ena_now) & ~dis_now;
         conv_start_o <= wr_ctrl & dat_i[`CTRL_START];
      end
   end

   // ----------------------------------------------------------------------
   // sleep control
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         sleep_mode_reg <= 1'b0;
         sleep_o        <= 1'b0;
      end else if (ce_i) begin
         if (wr_mode) begin
            sleep_mode_reg <= dat_i[`MODE_SLEEP];
         end
         if (!sleep_mode_reg) begin
            sleep_o <= 1'b0;
         end else if (eoc_i) begin
            sleep_o <= 1'b1;
         end else if (conv_start_o) begin
            sleep_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // interrupt
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_reg <= `RST_STAT;
         irq_stat_reg <= `RST_STAT;
         irq_o        <= 1'b0;
      end else if (ce_i) begin
         if (wr_mask) begin
            irq_mask_reg <= dat_i[`ST_WIDTH-1:0];
         end
         irq_stat_reg <= irq_stat_next;
         irq_o        <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // ----------------------------------------------------------------------
   // per-channel results
   // ----------------------------------------------------------------------
   integer k;
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (k = 0; k < NCH; k = k + 1) begin
            cdr_mem[k] <= {DW{1'b0}};
         end
      end else if (ce_i && eoc_ok) begin
         cdr_mem[eoc_chan_i] <= eoc_data_i;
      end
   end

endmodule // adc_result_status_flags

`default_nettype wire

/* File: verification/adc_flags_sva.sv */
// port assertions of the converter flag block
// assumes one clock and a synchronous active-high reset
`default_nettype none
module adc_flags_sva #(parameter NCH = 8) (
   input wire logic           clk_i,
   input wire logic           rst_i,
   input wire logic           ce_i,
   input wire logic           cyc_i,
   input wire logic           stb_i,
   input wire logic           we_i,
   input wire logic           ack_o,
   input wire logic           eoc_i,
   input wire logic [NCH-1:0] chan_en_o,
   input wire logic           conv_start_o,
   input wire logic           sleep_o,
   input wire logic           irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr;
   assign wr = cyc_i & stb_i & we_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // --------------------------------
   // port relations
   // --------------------------------
   AST_ACK_NEXT: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
      else $error("no ack");
   AST_ACK_ONCE: assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack held");
   AST_ACK_CAUSE: assert property ($rose(ack_o) |-> $past(cyc_i))
      else $error("ack unasked");
   AST_SLEEP_AFTER_EOC: assert property ($rose(sleep_o) |-> $past(eoc_i))
      else $error("sleep early");
   AST_START_ONCE: assert property (conv_start_o |=> !conv_start_o)
      else $error("start held");
   AST_START_CAUSE: assert property ($rose(conv_start_o) |-> $past(wr) || $past(wr, 2))
      else $error("start unasked");
   AST_EN_CAUSE: assert property (!$stable(chan_en_o) |-> $past(wr))
      else $error("enables moved");
   AST_IRQ_CAUSE: assert property ($rose(irq_o) |->
      $past(eoc_i) || $past(eoc_i, 2) || $past(wr) || $past(wr, 2))
      else $error("irq unasked");
endmodule // adc_flags_sva
bind adc_result_status_flags adc_flags_sva #(.NCH(NCH)) sva (.*);
`default_nettype wire

/* File: verification/conv_core_model.sv */
// behavioural conversion core facing the flag block
// assumes the bench commands extra ends of conversion through trig_i
`default_nettype none
module conv_core_model #(parameter LAT = 6) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic       trig_i,
   input  wire logic [2:0] trig_chan_i,
   input  wire logic [9:0] trig_data_i,
   output logic            eoc_o,
   output logic [2:0]      chan_o,
   output logic [9:0]      data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int         cnt;
   logic       auto_end;
   logic [9:0] last = '0;
   // --------------------------------
   // conversion timing
   // --------------------------------
   always @(posedge clk_i) begin
      if (rst_i)
         cnt <= 0;
      else if (start_i)
         cnt <= LAT;
      else if (cnt != 0)
         cnt <= cnt - 1;
      if (eoc_o)
         last <= data_o;
   end
   assign auto_end = (cnt == 1);
   assign eoc_o    = trig_i | auto_end;
   assign chan_o   = trig_i ? trig_chan_i : 3'h0;
   // no stale value on the data lines outside a result
   assign data_o   = trig_i ? trig_data_i : auto_end ? 10'h2c3 : ~last;
endmodule // conv_core_model
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench of the converter flag block
// assumes the answer to each bus request comes one cycle after it is taken
`include "adc_flags_consts.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, trig = 0;
   logic [7:0]  adr_i = '0, chan_en_o;
   logic [31:0] dat_i = '0, dat_o, q;
   logic [2:0]  tch = '0, ech;
   logic [9:0]  dv = 10'h123, tdat = '0, edat;
   logic        ack_o, eoc, conv_start_o, sleep_o, irq_o;
   int          mismatches = 0, samples_checked = 0;
   always #5 clk_i = ~clk_i;
   adc_result_status_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .adr_i(adr_i),
      .dat_i(dat_i), .sel_i(4'hf), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
      .ack_o(ack_o), .eoc_i(eoc), .eoc_chan_i(ech), .eoc_data_i(edat), .chan_en_o(chan_en_o),
      .conv_start_o(conv_start_o), .sleep_o(sleep_o), .irq_o(irq_o));
   conv_core_model core (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o), .trig_i(trig),
      .trig_chan_i(tch), .trig_data_i(tdat), .eoc_o(eoc), .chan_o(ech), .data_o(edat));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bus cycle; t = {end of conversion, channel} at the taking edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] t);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      {trig, tch, tdat} <= {t, dv};
      do begin
         @(posedge clk_i);
         trig <= 1'b0;
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
      if (n >= 20)
         chk("ack", 32'h0000_0001, 32'h0000_0000);
   endtask
   task automatic rd(input logic [7:0] a, input logic [3:0] t, input logic [31:0] e);
      wb(a, 1'b0, '0, t);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic ev(input logic [2:0] c);
      @(posedge clk_i);
      {trig, tch, tdat} <= {1'b1, c, dv};
      @(posedge clk_i);
      trig <= 1'b0;
   endtask
   task automatic t_start();
      rd(`OFF_STATUS, 0, 32'h0000_0000);
      rd(8'hfc, 0, 32'h0000_0000);
      wb(`OFF_CH_ENA, 1'b1, 32'h0000_00ff, 0);
      rd(`OFF_CH_STAT, 0, 32'h0000_00ff);
   endtask
   task automatic t_plain();
      ev(3'd1);
      rd(`OFF_CDR0 + 8'h04, 0, 32'h0000_0123);
      rd(`OFF_STATUS, 0, 32'h0001_0000);
      rd(`OFF_LATEST, 0, 32'h0000_1123);
      rd(`OFF_STATUS, 0, 32'h0000_0000);
   endtask
   task automatic t_cdr_hit();
      ev(3'd4);
      ev(3'd2);
      rd(`OFF_STATUS, 0, 32'h0003_0014);
      rd(`OFF_CDR0 + 8'h10, 4'ha, 32'h0000_0123);
      rd(`OFF_STATUS, 0, 32'h0003_0404);
   endtask
   task automatic t_status_hit();
      rd(`OFF_STATUS, 4'ha, 32'h0001_0004);
      rd(`OFF_STATUS, 0, 32'h0003_0404);
      rd(`OFF_LATEST, 0, 32'h0000_2123);
      ev(3'd6);
      ev(3'd6);
      rd(`OFF_CDR0 + 8'h18, 0, 32'h0000_0123);
      rd(`OFF_STATUS, 4'he, 32'h0003_4000);
      rd(`OFF_LATEST, 0, 32'h0000_6123);
      rd(`OFF_STATUS, 4'hb, 32'h0002_0000);
      rd(`OFF_STATUS, 0, 32'h0001_0008);
   endtask
   task automatic t_disable();
      rd(`OFF_LATEST, 0, 32'h0000_3123);
      ev(3'd1);
      dv = 10'h35a;
      wb(`OFF_CH_DIS, 1'b1, 32'h0000_0080, 4'h9);
      chk("chan_en", 32'h0000_007f, {24'h00_0000, chan_en_o});
      rd(`OFF_STATUS, 0, 32'h0003_0202);
      rd(`OFF_CDR0 + 8'h04, 0, 32'h0000_035a);
      rd(`OFF_LATEST, 0, 32'h0000_135a);
      ev(3'd7);
      rd(`OFF_STATUS, 0, 32'h0000_0000);
   endtask
   task automatic t_irq();
      rd(`OFF_IRQ_STAT, 0, 32'h0003_465e);
      wb(`OFF_IRQ_MASK, 1'b1, 32'h0001_0000, 0);
      ev(3'd0);
      repeat (2) @(negedge clk_i);
      chk("irq", 32'h0000_0001, {31'h0, irq_o});
      rd(`OFF_IRQ_STAT, 0, 32'h0001_0001);
      @(negedge clk_i);
      chk("irq", 32'h0000_0000, {31'h0, irq_o});
      wb(`OFF_IRQ_MASK, 1'b1, 32'h0000_0002, 0);
      ev(3'd0);
      repeat (2) @(negedge clk_i);
      chk("irq", 32'h0000_0000, {31'h0, irq_o});
   endtask
   task automatic t_sleep();
      wb(`OFF_MODE, 1'b1, 32'h0000_0001, 0);
      repeat (8) @(negedge clk_i);
      chk("sleep", 32'h0000_0000, {31'h0, sleep_o});
      wb(`OFF_CTRL, 1'b1, 32'h0000_0001, 0);
      for (int i = 0; i < 20 && sleep_o !== 1'b1; i++) @(negedge clk_i);
      chk("sleep", 32'h0000_0001, {31'h0, sleep_o});
   endtask
   task automatic conclude();
      if (mismatches == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_start();
      t_plain();
      t_cdr_hit();
      t_status_hit();
      t_disable();
      t_irq();
      t_sleep();
      conclude();
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      mismatches++;
      conclude();
   end
endmodule // tb
`default_nettype wire
